// file: hdl/rss_top.sv
// Reset and start-up sequencer with APB register access.
// Assumes all monitor and pin inputs are synchronous to pclk and that
// presetn is the true power-on reset of the always-on domain.
`timescale 1ns/100ps
module rss_top #(
    parameter int PUT_CYCLES = rss_pkg::PUT_CYC,
    parameter int BOD_CYCLES = rss_pkg::BOD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok,
    input wire logic supply_above_bod,
    input wire logic master_clear_pin,
    input wire logic osc_cycle_tick,
    input wire logic watchdog_reset,
    input wire logic watchdog_wake,
    input wire logic core_sleeping,
    output logic chip_reset_n,
    output logic core_stall,
    output logic divided_clock_output,
    output logic divided_clock_oe,
    output logic port_a_bit3_in,
    output logic [7:0] oscillator_trim_value,
    output logic [2:0] reset_cause
);
    import rss_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic is_crystal(input logic [2:0] sel);
        is_crystal = (sel == OSC_LP) || (sel == OSC_XT) || (sel == OSC_HS);
    endfunction

    logic [6:0] config_q;
    logic [7:0] scratch_q;
    logic [1:0] pwr_flag_q;
    logic timeout_flag_q;
    logic powerdown_flag_q;
    rss_state_t state_q;
    rss_state_t state_d;
    logic [31:0] put_cnt_q;
    logic [31:0] bod_cnt_q;
    logic [15:0] master_clear_pin_cnt_q;
    logic [10:0] ost_cnt_q;
    logic ost_por_q;
    logic ost_wake_q;
    logic [1:0] div_q;
    logic wr_en;
    logic rd_sel;
    logic master_clear_pin_int;
    logic master_clear_pin_rst;
    logic bod_event;
    logic put_done;
    logic ost_done;
    logic wdt_rst_run;
    logic wake_ost;

    wire [2:0] osc_sel = config_q[CFG_OSC_LSB +: 3];
    wire put_off = config_q[CFG_PUT_DIS];
    wire bod_on = config_q[CFG_BOD_EN];

    ////////////////////////////////////////////////////////////////////
    // APB slave: zero wait state, ready registered from setup and high in the access cycle
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_sel = psel & ~penable & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    OFS_CONFIG: prdata[6:0] <= config_q;
                    OFS_STATUS: begin
                        prdata[ST_PD_BIT] <= powerdown_flag_q;
                        prdata[ST_TO_BIT] <= timeout_flag_q;
                        prdata[ST_CAUSE_LSB +: 3] <= reset_cause;
                        prdata[ST_STATE_LSB +: 6] <= state_q;
                        prdata[ST_PIN_BIT] <= master_clear_pin;
                    end
                    OFS_PWRFLG: prdata[1:0] <= pwr_flag_q;
                    OFS_TRIM: prdata[7:0] <= oscillator_trim_value; // R3
                    OFS_SCRATCH: prdata[7:0] <= scratch_q;
                    default: pslverr <= 1'b1;
                endcase
                if (!rd_sel) begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Configuration word, unprogrammed after power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_q <= CFG_RST;
        end else if (wr_en && paddr == OFS_CONFIG) begin
            config_q <= pwdata[6:0];
        end
    end

    // Retained across every reset, no reset term at all
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == OFS_SCRATCH) begin
            scratch_q <= pwdata[7:0]; // R6
        end
    end

    // Trim register: reloaded with TRIM_RST by chip reset, kept over watchdog wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oscillator_trim_value <= TRIM_RST;
        end else if (!chip_reset_n) begin
            oscillator_trim_value <= TRIM_RST; // R5
        end else if (wr_en && paddr == OFS_TRIM) begin
            oscillator_trim_value <= pwdata[7:0]; // R3
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Master-clear path: tie-off and width filter
    assign master_clear_pin_int = config_q[CFG_MASTER_CLEAR_PIN_EN] ? master_clear_pin : 1'b1; // R23
    assign master_clear_pin_rst = (master_clear_pin_cnt_q == 16'(MASTER_CLEAR_PIN_CYC)); // R7

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_clear_pin_cnt_q <= 16'h0000;
            port_a_bit3_in <= 1'b0;
        end else begin
            port_a_bit3_in <= config_q[CFG_MASTER_CLEAR_PIN_EN] ? 1'b0 : master_clear_pin;
            if (master_clear_pin_int) begin
                master_clear_pin_cnt_q <= 16'h0000;
            end else if (!master_clear_pin_rst) begin
                master_clear_pin_cnt_q <= master_clear_pin_cnt_q + 16'h0001; // R7
            end
        end
    end

    // Brown-out dip duration counter
    assign bod_event = bod_on && (bod_cnt_q == 32'(BOD_CYCLES)); // R15 R16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bod_cnt_q <= 32'h0000_0000;
        end else if (supply_above_bod || !bod_on) begin
            bod_cnt_q <= 32'h0000_0000;
        end else if (bod_cnt_q != 32'(BOD_CYCLES)) begin
            bod_cnt_q <= bod_cnt_q + 32'h0000_0001; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    assign put_done = (put_cnt_q == 32'(PUT_CYCLES - 1));
    assign ost_done = osc_cycle_tick && (ost_cnt_q == OST_CYC - 11'h001);
    assign wdt_rst_run = watchdog_reset; // R8
    assign wake_ost = watchdog_wake && core_sleeping && is_crystal(osc_sel);

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_POR: begin
                if (supply_ok) begin
                    state_d = S_BOD; // R9 R20
                end
            end
            S_BOD: begin
                if (supply_above_bod || !bod_on) begin // R17
                    if (!put_off) begin
                        state_d = S_PUT; // R10 R11
                    end else if (ost_por_q && is_crystal(osc_sel)) begin
                        state_d = S_OST; // R14
                    end else begin
                        state_d = S_HOLD; // R18 R21
                    end
                end
            end
            S_PUT: begin
                if (bod_on && !supply_above_bod) begin
                    state_d = S_BOD; // R19
                end else if (put_done) begin
                    if (ost_por_q && is_crystal(osc_sel)) begin
                        state_d = S_OST; // R13 R20
                    end else begin
                        state_d = S_HOLD;
                    end
                end
            end
            S_OST: begin
                if (ost_done) begin
                    state_d = ost_wake_q ? S_RUN : S_HOLD; // R13
                end
            end
            S_HOLD: begin
                if (master_clear_pin_int) begin
                    state_d = S_RUN; // R22
                end
            end
            S_RUN: begin
                if (master_clear_pin_rst || wdt_rst_run) begin
                    state_d = S_HOLD;
                end else if (wake_ost) begin
                    state_d = S_OST; // R14
                end
            end
            default: state_d = S_POR;
        endcase
        if (bod_event && state_q != S_POR && state_q != S_BOD) begin
            state_d = S_BOD; // R16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_POR;
        end else begin
            state_q <= state_d;
        end
    end

    // Power-up timer counter, restarts on every entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            put_cnt_q <= 32'h0000_0000;
        end else if (state_q != S_PUT) begin
            put_cnt_q <= 32'h0000_0000; // R19
        end else if (!put_done) begin
            put_cnt_q <= put_cnt_q + 32'h0000_0001; // R10
        end
    end

    // Start-up timer counts oscillator input cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ost_cnt_q <= 11'h000;
        end else if (state_q != S_OST) begin
            ost_cnt_q <= 11'h000;
        end else if (osc_cycle_tick) begin
            ost_cnt_q <= ost_cnt_q + 11'h001; // R13
        end
    end

    // Which start-up path is in progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ost_por_q <= 1'b1;
            ost_wake_q <= 1'b0;
        end else begin
            if (bod_event || state_q == S_HOLD) begin
                ost_por_q <= 1'b0; // R14
            end
            if (state_q == S_RUN && state_d == S_OST) begin
                ost_wake_q <= 1'b1;
            end else if (state_d != S_OST) begin
                ost_wake_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reset outputs, released on a pclk edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_reset_n <= 1'b0;
            core_stall <= 1'b1;
        end else begin
            // Wake start-up keeps the chip out of reset from its first edge
            chip_reset_n <= (state_d == S_RUN) ||
                            (state_d == S_OST &&
                             (ost_wake_q || state_q == S_RUN)); // R5 R26
            core_stall <= (state_d != S_RUN); // R26
        end
    end

    // Cause code and time-out/power-down flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cause <= CAUSE_POR; // R4
            timeout_flag_q <= 1'b1;
            powerdown_flag_q <= 1'b1;
        end else if (bod_event && state_q != S_POR && state_q != S_BOD) begin
            reset_cause <= CAUSE_BOD; // R4
            timeout_flag_q <= 1'b1;
            powerdown_flag_q <= 1'b1;
        end else if (state_q == S_RUN) begin
            if (wdt_rst_run) begin
                reset_cause <= core_sleeping ? CAUSE_WDT_SLEEP : CAUSE_WDT_RUN;
                timeout_flag_q <= 1'b0; // R4
            end else if (master_clear_pin_rst) begin
                reset_cause <= core_sleeping ? CAUSE_MASTER_CLEAR_PIN_SLEEP
                                             : CAUSE_MASTER_CLEAR_PIN_RUN; // R4
                if (core_sleeping) begin
                    timeout_flag_q <= 1'b1;
                    powerdown_flag_q <= 1'b0;
                end
            end else if (watchdog_wake && core_sleeping) begin
                timeout_flag_q <= 1'b0; // R5
                powerdown_flag_q <= 1'b0;
            end
        end
    end

    // Power flags: hardware clear wins over software set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_flag_q <= 2'b00; // R25
        end else begin
            if (wr_en && paddr == OFS_PWRFLG) begin
                pwr_flag_q <= pwr_flag_q | pwdata[1:0]; // R25
            end
            // Brown-out clear lands last, so it wins bit 0 only
            if (bod_event && state_q != S_POR && state_q != S_BOD) begin
                pwr_flag_q[PF_BOD_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Divided clock on the shared oscillator pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'b00;
            divided_clock_output <= 1'b0;
            divided_clock_oe <= 1'b0;
        end else begin
            div_q <= div_q + 2'b01;
            divided_clock_output <= div_q[1]; // R1
            divided_clock_oe <= (osc_sel == OSC_RC_OUT) ||
                                (osc_sel == OSC_INT_OUT); // R2 R24
        end
    end

endmodule

// file: pkg/rss_pkg.sv
// Constants, states and register map of the reset and start-up sequencer.
// Assumes a 125 MHz APB clock; analog monitors arrive as clean levels.
// How it works
// [R1] Clock output pin carries system clock divided by four
// [R2] Clock output only in resistor-capacitor and internal modes
// [R3] Software loads trim literal into trim register
// [R4] Six reset causes recorded in cause field
// [R5] Chip reset clears registers; watchdog wake does not
// [R6] Scratch register never touched by any reset
// [R7] Master-clear low pulses filtered by width
// [R8] Watchdog reset never drives master-clear pin
// [R9] Power-on hold only; later supply fall ignored
// [R10] Power-up timer 72 ms, after power-on or brown-out
// [R11] Timer disable bit one turns timer off
// [R12] Configurer enables timer whenever brown-out enabled; not enforced, disable bit still skips timer with brown-out on
// [R13] Start-up timer counts 1024 oscillator cycles
// [R14] Start-up count: crystal modes, power-on or wake
// [R15] Brown-out enable bit one turns detection on
// [R16] Brown-out resets after dip exceeds minimum duration
// [R17] Hold reset until supply above brown-out level
// [R18] Brown-out skips power-up timer when disabled
// [R19] Dip during power-up timer restarts timer afterwards
// [R20] Power-on, then power-up timer, then start-up count
// [R21] External clock, timer off: no added delay
// [R22] Time-outs run regardless of master-clear pin
// [R23] Enable bit zero: pin is I/O, clear inactive
// [R24] Select codes 111 and 101 enable clock output
// [R25] Power-on flag zero after power-on, software sets
// [R26] Final reset release synchronous to system clock
package rss_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CONFIG = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_PWRFLG = 12'h008;
    localparam logic [11:0] OFS_TRIM = 12'h00c;
    localparam logic [11:0] OFS_SCRATCH = 12'h010;
    // Configuration field positions and reset value (unprogrammed)
    localparam int CFG_OSC_LSB = 0;
    localparam int CFG_PUT_DIS = 4;
    localparam int CFG_MASTER_CLEAR_PIN_EN = 5;
    localparam int CFG_BOD_EN = 6;
    localparam logic [6:0] CFG_RST = 7'h7f;
    // Status field positions
    localparam int ST_PD_BIT = 0;
    localparam int ST_TO_BIT = 1;
    localparam int ST_CAUSE_LSB = 4;
    localparam int ST_STATE_LSB = 8;
    localparam int ST_PIN_BIT = 16;
    // Power flag positions and trim reset value
    localparam int PF_BOD_BIT = 0;
    localparam int PF_POR_BIT = 1;
    localparam logic [7:0] TRIM_RST = 8'h80;
    // Oscillator select codes
    localparam logic [2:0] OSC_LP = 3'h0;
    localparam logic [2:0] OSC_XT = 3'h1;
    localparam logic [2:0] OSC_HS = 3'h2;
    localparam logic [2:0] OSC_EC = 3'h3;
    localparam logic [2:0] OSC_INT_OUT = 3'h5;
    localparam logic [2:0] OSC_RC_OUT = 3'h7;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int PUT_MS = 72;
    localparam int PUT_CYC = PUT_MS * 1000 * CLK_MHZ;
    localparam int BOD_MIN_US = 100;
    localparam int BOD_CYC = BOD_MIN_US * CLK_MHZ;
    localparam int MASTER_CLEAR_PIN_MIN_NS = 2000;
    localparam int MASTER_CLEAR_PIN_CYC = (MASTER_CLEAR_PIN_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [10:0] OST_CYC = 11'h400;
    // Reset causes
    typedef enum logic [2:0] {
        CAUSE_POR = 3'h0,
        CAUSE_WDT_RUN = 3'h1,
        CAUSE_WDT_SLEEP = 3'h2,
        CAUSE_MASTER_CLEAR_PIN_RUN = 3'h3,
        CAUSE_MASTER_CLEAR_PIN_SLEEP = 3'h4,
        CAUSE_BOD = 3'h5
    } rss_cause_t;
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        S_POR = 6'h01,
        S_BOD = 6'h02,
        S_PUT = 6'h04,
        S_OST = 6'h08,
        S_HOLD = 6'h10,
        S_RUN = 6'h20
    } rss_state_t;
endpackage

// file: bench/rss_assertions.sv
// Checker for the reset and start-up sequencer: APB timing, clock
// divider and reset relations. Assumes binding to rss_top ports only.
`timescale 1ns/100ps
module rss_checker #(
    parameter int PUT_CYCLES = 40,
    parameter int BOD_CYCLES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic master_clear_pin,
    input wire logic supply_above_bod,
    input wire logic watchdog_reset,
    input wire logic core_sleeping,
    input wire logic chip_reset_n,
    input wire logic core_stall,
    input wire logic divided_clock_output,
    input wire logic [7:0] oscillator_trim_value,
    input wire logic [2:0] reset_cause
);
    logic [8:0] low_run_q;

    // Length of the current low run on the master-clear pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_run_q <= 9'h000;
        end else if (master_clear_pin) begin
            low_run_q <= 9'h000;
        end else if (low_run_q != 9'h1ff) begin
            low_run_q <= low_run_q + 9'h001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // One more high, two low, then high again
    sequence s_div_tail;
        divided_clock_output ##1 !divided_clock_output[*2]
            ##1 divided_clock_output;
    endsequence

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("pready without setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_div_period: assert property ($rose(divided_clock_output) |=> s_div_tail)
        else $error("clock out not a quarter rate");
    a_stall_in_reset: assert property (!chip_reset_n |-> core_stall)
        else $error("core runs in reset");
    a_release_run: assert property ($rose(chip_reset_n) |-> ##[0:1] !core_stall)
        else $error("release not with run");
    a_short_ignored: assert property (!master_clear_pin && low_run_q < 9'h096
        && chip_reset_n && supply_above_bod && !watchdog_reset
        |=> chip_reset_n)
        else $error("short clear pulse reset chip");
    a_wdt_cause: assert property (watchdog_reset && !core_sleeping
        && !core_stall |-> ##[1:4] reset_cause == 3'h1)
        else $error("watchdog cause not recorded");
    a_trim_reset: assert property (!chip_reset_n |=> oscillator_trim_value == 8'h80)
        else $error("trim not reset");
endmodule

////////////////////////////////////////////////////////////////////////
bind rss_top rss_checker #(
    .PUT_CYCLES(PUT_CYCLES),
    .BOD_CYCLES(BOD_CYCLES)
) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr),
    .master_clear_pin(master_clear_pin),
    .supply_above_bod(supply_above_bod),
    .watchdog_reset(watchdog_reset), .core_sleeping(core_sleeping),
    .chip_reset_n(chip_reset_n), .core_stall(core_stall),
    .divided_clock_output(divided_clock_output),
    .oscillator_trim_value(oscillator_trim_value),
    .reset_cause(reset_cause)
);

// file: bench/tb_rss_top.sv
// Testbench of the reset and start-up sequencer, driven over APB.
// Assumes short timer parameters and an oscillator tick every 2 cycles.
`timescale 1ns/100ps
`define CHK(nm, ex, ac) begin tests_run++; if ((ac) !== (ex)) begin \
    bad_count++; $display("BAD %s exp %0h got %0h", nm, ex, ac); end end
module tb_rss_top;
    import rss_pkg::*;
    localparam int PUT_N = 40;
    localparam int BOD_N = 8;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, supply_ok = 1'b0, supply_above_bod = 1'b1;
    logic master_clear_pin = 1'b1, osc_cycle_tick = 1'b0;
    logic watchdog_reset = 1'b0, watchdog_wake = 1'b0, core_sleeping = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, chip_reset_n, core_stall, port_a_bit3_in;
    logic divided_clock_output, divided_clock_oe;
    logic [7:0] oscillator_trim_value;
    logic [2:0] reset_cause;
    int bad_count = 0;
    int tests_run = 0;

    rss_top #(.PUT_CYCLES(PUT_N), .BOD_CYCLES(BOD_N)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
        .supply_above_bod(supply_above_bod),
        .master_clear_pin(master_clear_pin),
        .osc_cycle_tick(osc_cycle_tick), .watchdog_reset(watchdog_reset),
        .watchdog_wake(watchdog_wake), .core_sleeping(core_sleeping),
        .chip_reset_n(chip_reset_n), .core_stall(core_stall),
        .divided_clock_output(divided_clock_output),
        .divided_clock_oe(divided_clock_oe),
        .port_a_bit3_in(port_a_bit3_in),
        .oscillator_trim_value(oscillator_trim_value),
        .reset_cause(reset_cause)
    );

    // Clock and oscillator ticks
    always #4 pclk = ~pclk;
    always @(posedge pclk) osc_cycle_tick <= ~osc_cycle_tick;

    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
            input logic [31:0] x, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(nm, x, r & m)
    endtask

    task automatic wait_rn(input logic v, input int lim, output int n);
        n = 0;
        while (chip_reset_n !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic dip(input int c);
        supply_above_bod <= 1'b0;
        cyc(c);
        supply_above_bod <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd_chk(OFS_CONFIG, 32'hffffffff, 32'h7f, "config");
        rd_chk(OFS_PWRFLG, 32'hffffffff, 32'h0, "pflag");
        apb(1'b0, 12'h014, 32'h0, r, e);
        `CHK("unmapped", 1'b1, e)
        `CHK("oe 111", 1'b1, divided_clock_oe)
        wr(OFS_PWRFLG, 32'h2);
        rd_chk(OFS_PWRFLG, 32'h3, 32'h2, "pflag set");
        wr(OFS_CONFIG, 32'h65);
        cyc(2);
        `CHK("oe 101", 1'b1, divided_clock_oe)
        wr(OFS_CONFIG, 32'h61);
        cyc(2);
        `CHK("oe xt", 1'b0, divided_clock_oe)
        `CHK("por hold", 1'b0, chip_reset_n)
    endtask

    task automatic t_powerup();
        int n;
        supply_ok <= 1'b1;
        cyc(20);
        rd_chk(OFS_STATUS, 32'h3f00, 32'h400, "in timer");
        cyc(40);
        rd_chk(OFS_STATUS, 32'h3f00, 32'h800, "in ost");
        wait_rn(1'b1, 3000, n);
        `CHK("ost len", 1'b1, n > 1900 && n < 2100)
        rd_chk(OFS_STATUS, 32'h3f70, 32'h2000, "run por");
    endtask

    task automatic t_master_clear_pin();
        int n;
        wr(OFS_SCRATCH, 32'h1234);
        wr(OFS_TRIM, 32'h5a);
        cyc(1);
        `CHK("trim port", 8'h5a, oscillator_trim_value)
        master_clear_pin <= 1'b0;
        cyc(100);
        master_clear_pin <= 1'b1;
        cyc(3);
        `CHK("short pulse", 1'b1, chip_reset_n)
        master_clear_pin <= 1'b0;
        cyc(300);
        `CHK("long pulse", 1'b0, chip_reset_n)
        master_clear_pin <= 1'b1;
        wait_rn(1'b1, 50, n);
        `CHK("quick exit", 1'b1, n < 10)
        rd_chk(OFS_STATUS, 32'h70, 32'h30, "cause clr");
        rd_chk(OFS_TRIM, 32'hff, 32'h80, "trim reset");
        rd_chk(OFS_SCRATCH, 32'hffff, 32'h34, "scratch");
        rd_chk(OFS_PWRFLG, 32'h2, 32'h2, "por kept");
    endtask

    // Watchdog reset while running or sleeping, chip resumes on its own
    task automatic wdt_rst(input logic s, input logic [31:0] x);
        int n;
        core_sleeping <= s;
        watchdog_reset <= 1'b1;
        cyc(1);
        watchdog_reset <= 1'b0;
        wait_rn(1'b0, 10, n);
        wait_rn(1'b1, 50, n);
        `CHK("wdt back", 1'b1, n < 50)
        core_sleeping <= 1'b0;
        rd_chk(OFS_STATUS, 32'h72, x, "cause wdt");
    endtask

    task automatic t_wake();
        int n;
        wr(OFS_TRIM, 32'h33);
        core_sleeping <= 1'b1;
        watchdog_wake <= 1'b1;
        cyc(1);
        watchdog_wake <= 1'b0;
        cyc(3);
        `CHK("wake stall", 1'b1, core_stall)
        `CHK("wake no rst", 1'b1, chip_reset_n)
        n = 0;
        while (core_stall !== 1'b0 && n < 3000) begin
            cyc(1);
            n++;
        end
        `CHK("wake ost", 1'b1, n > 1900 && n < 2100)
        core_sleeping <= 1'b0;
        rd_chk(OFS_TRIM, 32'hff, 32'h33, "trim kept");
        rd_chk(OFS_STATUS, 32'h3, 32'h0, "wake flags");
    endtask

    task automatic t_bod();
        int n;
        dip(4);
        cyc(3);
        `CHK("short dip", 1'b1, chip_reset_n)
        supply_above_bod <= 1'b0;
        cyc(20);
        `CHK("dip reset", 1'b0, chip_reset_n)
        supply_above_bod <= 1'b1;
        cyc(10);
        dip(12);
        wait_rn(1'b1, 200, n);
        `CHK("timer restart", 1'b1, n >= PUT_N && n < 60)
        rd_chk(OFS_STATUS, 32'h73, 32'h53, "cause bod");
        rd_chk(OFS_PWRFLG, 32'h3, 32'h2, "bod flag");
    endtask

    task automatic t_modes();
        int n;
        wr(OFS_CONFIG, 32'h41);
        master_clear_pin <= 1'b0;
        cyc(300);
        `CHK("clear off", 1'b1, chip_reset_n)
        master_clear_pin <= 1'b1;
        cyc(2);
        `CHK("pin as io", 1'b1, port_a_bit3_in)
        wr(OFS_CONFIG, 32'h73);
        dip(20);
        wait_rn(1'b1, 50, n);
        `CHK("ext no delay", 1'b1, n < 6)
        wr(OFS_CONFIG, 32'h33);
        dip(20);
        `CHK("bod off", 1'b1, chip_reset_n)
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run of about 5000 cycles
    initial begin
        cyc(20000);
        bad_count++;
        results();
    end

    // Main sequence
    initial begin
        cyc(2);
        presetn <= 1'b1;
        t_regs();
        t_powerup();
        t_master_clear_pin();
        wdt_rst(1'b0, 32'h10);
        wdt_rst(1'b1, 32'h20);
        t_wake();
        t_bod();
        t_modes();
        results();
    end
endmodule
